// [core/serial_in_latched_parallel_out.sv]
`timescale 1ns/1ns
module serial_in_latched_parallel_out (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // pins from the host
  input wire logic shift_clk,
  input wire logic latch_clk,
  input wire logic chain_clear_n,
  input wire logic out_enable_n,
  input wire logic serial_in,
  // parallel output pin, two signals per bit
  output logic [7:0] par_out,
  output logic [7:0] par_oe_n,
  // cascade
  output logic cascade_out,
  // stored word stream to the core side
  output logic word_valid,
  output logic [7:0] word_data,
  input wire logic word_ready,
  output logic word_overflow
);
  sipo_latch_pkg::pin_in_type sync1, sync2, sync_prev;
  logic [sipo_latch_pkg::WIDTH-1:0] stage_bits;
  logic [sipo_latch_pkg::WIDTH-1:0] storage;
  logic shift_rise, latch_rise;
  logic [7:0] buf_mem [0:1];
  logic buf_wr_ptr, buf_rd_ptr;
  logic [1:0] buf_count;
  logic buf_in_ready;
  logic [7:0] loaded_word;
  logic push;
  logic pop;
  logic [1:0] next_count;
  logic next_rd_ptr;
  logic [7:0] next_head;

  // clear forces zeros even before the chain flops have caught up
  function automatic logic [7:0] latch_word(input logic clear_n, input logic [7:0] chain);
    if (clear_n) begin
      return chain;
    end
    return sipo_latch_pkg::CHAIN_CLEARED;
  endfunction : latch_word

  // low-to-high step between two synchronised samples
  function automatic logic rise_of(input logic level_now, input logic level_before);
    return level_now & ~level_before;
  endfunction : rise_of

  // two flops on every pin; first stage read only by the second
  // reset to idle levels so no false edge or clear follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= sipo_latch_pkg::PIN_IDLE;
    end else if (clk_en) begin
      sync1 <= {shift_clk, latch_clk, chain_clear_n, out_enable_n, serial_in};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync2 <= sipo_latch_pkg::PIN_IDLE;
    end else if (clk_en) begin
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_prev <= sipo_latch_pkg::PIN_IDLE;
    end else if (clk_en) begin
      sync_prev <= sync2;
    end
  end

  assign shift_rise = rise_of(sync2.shift_clk, sync_prev.shift_clk);
  assign latch_rise = rise_of(sync2.latch_clk, sync_prev.latch_clk);

  // clear is sampled, not truly asynchronous: it acts within the sync latency
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_bits <= sipo_latch_pkg::CHAIN_CLEARED;
    end else if (clk_en) begin
      if (!sync2.chain_clear_n) begin
        stage_bits <= sipo_latch_pkg::CHAIN_CLEARED;
      end else if (shift_rise) begin
        stage_bits <= {stage_bits[sipo_latch_pkg::WIDTH-2:0], sync2.serial_in};
      end
    end
  end

  // no reset on storage; takes pre-shift chain on a shared edge
  always_ff @(posedge clk) begin
    if (clk_en && latch_rise) begin
      storage <= latch_word(sync2.chain_clear_n, stage_bits);
    end
  end

  // cascade follows the last stage; clear wins over a shift in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cascade_out <= 1'b0;
    end else if (clk_en) begin
      if (!sync2.chain_clear_n) begin
        cascade_out <= 1'b0;
      end else if (shift_rise) begin
        cascade_out <= stage_bits[sipo_latch_pkg::LAST_STAGE-1];
      end
    end
  end

  // enable only gates the pin drivers, never the registers
  always_ff @(posedge clk) begin
    if (rst) begin
      par_oe_n <= sipo_latch_pkg::OE_OFF;
    end else if (clk_en) begin
      par_oe_n <= {sipo_latch_pkg::WIDTH{sync2.out_enable_n}};
    end
  end

  // par_out mirrors storage; clear alone leaves it
  always_ff @(posedge clk) begin
    if (rst) begin
      par_out <= sipo_latch_pkg::CHAIN_CLEARED;
    end else if (clk_en && latch_rise) begin
      par_out <= latch_word(sync2.chain_clear_n, stage_bits);
    end
  end

  // two-entry buffer: each latch event pushes the stored word unless the buffer is full
  assign loaded_word = latch_word(sync2.chain_clear_n, stage_bits);
  assign buf_in_ready = (buf_count != sipo_latch_pkg::BUF_DEPTH);

  always_comb begin
    push = latch_rise & buf_in_ready;
    pop = word_valid & word_ready;
    next_count = buf_count + {1'b0, push} - {1'b0, pop};
    next_rd_ptr = buf_rd_ptr;
    if (pop) begin
      next_rd_ptr = ~buf_rd_ptr;
    end
    // a word pushed into an emptying buffer is not in memory yet, so bypass it
    next_head = buf_mem[next_rd_ptr];
    if (push && next_count == 2'h1) begin
      next_head = loaded_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_count <= 2'h0;
    end else if (clk_en) begin
      buf_count <= next_count;
    end
  end

  // memory needs no reset: a slot read before it is written reaches word_data only while word_valid is low
  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      buf_mem[buf_wr_ptr] <= loaded_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_wr_ptr <= 1'b0;
    end else if (clk_en && push) begin
      buf_wr_ptr <= ~buf_wr_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_rd_ptr <= 1'b0;
    end else if (clk_en) begin
      buf_rd_ptr <= next_rd_ptr;
    end
  end

  // head of the buffer registered so the outputs come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      word_valid <= 1'b0;
      word_data <= sipo_latch_pkg::CHAIN_CLEARED;
    end else if (clk_en) begin
      word_valid <= (next_count != 2'h0);
      word_data <= next_head;
    end
  end

  // a pin source cannot be stalled, so a full buffer flags the lost word
  always_ff @(posedge clk) begin
    if (rst) begin
      word_overflow <= 1'b0;
    end else if (clk_en) begin
      word_overflow <= latch_rise & ~buf_in_ready;
    end
  end
endmodule : serial_in_latched_parallel_out

// [common/sipo_latch_pkg.sv]
package sipo_latch_pkg;
  localparam int WIDTH = 8;
  localparam int LAST_STAGE = 7;
  localparam int SYNC_DEPTH = 2;
  localparam logic [7:0] CHAIN_CLEARED = 8'h00;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [7:0] OE_OFF = 8'hFF;

  typedef struct packed {
    logic shift_clk;
    logic latch_clk;
    logic chain_clear_n;
    logic out_enable_n;
    logic serial_in;
  } pin_in_type;

  // idle pin levels: clocks low, clear and enable released
  localparam pin_in_type PIN_IDLE = '{shift_clk: 1'b0, latch_clk: 1'b0, chain_clear_n: 1'b1,
                                     out_enable_n: 1'b1, serial_in: 1'b0};

  typedef struct packed {
    logic [7:0] par_out;
    logic [7:0] par_oe_n;
    logic cascade_out;
  } pin_out_type;
endpackage : sipo_latch_pkg

// [verif/sipo_assertions.sv]
`timescale 1ns/1ns
module sipo_chk (
  // clock, reset, pins
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic latch_clk,
  input wire logic chain_clear_n,
  input wire logic out_enable_n,
  // outputs
  input wire logic [7:0] par_out,
  input wire logic [7:0] par_oe_n,
  input wire logic cascade_out,
  input wire logic word_overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // six cycles cover the two sync flops, edge detect and output register
  sequence clr_latch; !chain_clear_n [*6] ##1 !chain_clear_n && $rose(latch_clk); endsequence
  AST_OE: assert property ($stable(out_enable_n) [*6] |-> par_oe_n == {8{out_enable_n}}) else $error("oe");
  AST_CLR: assert property (!chain_clear_n [*6] |-> !cascade_out) else $error("clear");
  AST_HOLD_PAR: assert property (!latch_clk [*6] |-> $stable(par_out)) else $error("par hold");
  AST_HOLD_CHAIN: assert property ((!shift_clk && chain_clear_n) [*6] |-> $stable(cascade_out)) else $error("chain");
  AST_PAR_ZERO: assert property (clr_latch |-> ##[1:6] par_out == 8'h00) else $error("clear load");
  AST_PAR_CAUSE: assert property (!$stable(par_out) |-> latch_clk) else $error("par cause");
  AST_CASC_CAUSE: assert property ($changed(cascade_out) && chain_clear_n |-> $past(shift_clk)) else $error("casc");
  AST_OVF: assert property (word_overflow |=> !word_overflow) else $error("overflow");
endmodule : sipo_chk
bind serial_in_latched_parallel_out sipo_chk u_chk (.*);

// [verif/sipo_host.sv]
`timescale 1ns/1ns
module sipo_host (
  // pins to the register
  output logic shift_clk,
  output logic latch_clk,
  output logic serial_in
);
  // link clock runs only inside a pulse, 80 ns each level
  initial {shift_clk, latch_clk, serial_in} = 3'h0;
  task automatic pulse(input logic s, input logic l, input logic d);
    serial_in = d;
    #80 {shift_clk, latch_clk} = {s, l};
    #80 {shift_clk, latch_clk} = 2'h0;
    serial_in = ~d; // data no longer held after the edge
  endtask : pulse
endmodule : sipo_host

// [verif/serial_in_latched_parallel_out_tb.sv]
`timescale 1ns/1ns
module serial_in_latched_parallel_out_tb;
  logic clk = 0, rst = 1, clk_en = 1, chain_clear_n = 1, out_enable_n = 1, word_ready = 0, hold = 0;
  logic shift_clk, latch_clk, serial_in, cascade_out, word_valid, word_overflow;
  logic [7:0] par_out, par_oe_n, word_data, b, chain = 0, store = 0;
  logic [7:0] q[$];
  int n_mismatch = 0, tests_run = 0, drops = 0, ovfs = 0;
  sipo_host u_host (.*);
  serial_in_latched_parallel_out u_dut (.*);
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input logic s, input logic l, input logic d);
    @(posedge clk) #1;
    if (l && q.size() < 2) q.push_back(chain);
    else if (l) drops++;
    if (l) store = chain;
    u_host.pulse(s, l, d);
    if (s) chain = {chain[6:0], d};
  endtask : step
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // stalled reader lets the two-entry buffer fill and refuse
  always @(posedge clk) begin
    word_ready <= !hold && $urandom_range(1);
    ovfs += word_overflow === 1'h1;
    if (clk_en === 1'h1 && word_valid === 1'h1 && word_ready === 1'h1) chk(word_data, q.pop_front(), "word_data");
  end
  initial begin
    #200000 n_mismatch++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hFB72B073));
    repeat (8) @(posedge clk);
    #1 rst = 0;
    #64 chk(par_oe_n, 8'hFF, "par_oe_n");
    out_enable_n = 0;
    for (int i = 0; i < 9; i++) begin
      hold = i > 2 && i < 6;
      b = $urandom;
      for (int k = 7; k >= 0; k--) step(1, 0, b[k]);
      step(i[0], 1, 0);
      chk(par_out, store, "par_out");
      chk(cascade_out, {7'h0, chain[7]}, "cascade_out");
    end
    // frozen core misses a whole shift pulse
    @(posedge clk) #1 clk_en = 0;
    u_host.pulse(1, 0, 1);
    #8 clk_en = 1;
    chk(cascade_out, {7'h0, chain[7]}, "cascade_out");
    step(0, 1, 0);
    chk(par_out, store, "par_out");
    chain_clear_n = 0;
    chain = 0;
    #64 chk(cascade_out, 8'h00, "cascade_out");
    chk(par_out, store, "par_out");
    step(0, 1, 0);
    chk(par_out, 8'h00, "par_out");
    chain_clear_n = 1;
    out_enable_n = 1;
    #64 chk(par_oe_n, 8'hFF, "par_oe_n");
    out_enable_n = 0;
    #64 chk(par_oe_n, 8'h00, "par_oe_n");
    chk(par_out, store, "par_out");
    #400 chk(8'(q.size()), 8'h00, "words left");
    chk(8'(ovfs), 8'(drops), "word_overflow");
    report_and_stop;
  end
endmodule : serial_in_latched_parallel_out_tb
